// ### apc_pkg.sv
// Package: constants and types of the converter control block
`default_nettype none
package apc_pkg;
	// Command opcodes, received most significant bit first
	localparam logic [7:0] CMD_SYNC      = 8'hfc;
	localparam logic [7:0] CMD_SLEEP     = 8'hfd;
	localparam logic [7:0] CMD_RESET     = 8'hfe;
	localparam logic [7:0] CMD_WAKE      = 8'hfb;
	localparam logic [7:0] CMD_AUTO      = 8'h03;
	localparam logic [7:0] CMD_STOP_AUTO = 8'h0f;
	localparam logic [2:0] CMD_LAST_BIT  = 3'h7;
	// APB register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_RESULT   = 8'h08;
	localparam logic [7:0] ADDR_COUNT    = 8'h0c;
	// Status bit positions
	localparam int ST_SLEEP = 0;
	localparam int ST_AUTO  = 1;
	localparam int ST_READY = 2;
	// Rate generation
	localparam logic [8:0]  MOD_BASE_DIV   = 9'h080;
	localparam logic [12:0] CONV_MOD_TICKS = 13'h0500;
	localparam logic [1:0]  RATE_MAX       = 2'h2;
	localparam logic [2:0]  GAIN_16        = 3'h4;
	localparam logic [2:0]  GAIN_32        = 3'h5;
	localparam logic [1:0]  SHIFT_X2       = 2'h1;
	localparam logic [1:0]  SHIFT_X4       = 2'h2;
	localparam logic [1:0]  SHIFT_X8       = 2'h3;
	// Result saturation
	localparam logic [23:0] RES_POS_FS = 24'h7fffff;
	localparam logic [23:0] RES_NEG_FS = 24'h800000;
	localparam int CTRL_W = 6;
	typedef struct packed {
		logic [2:0] gain;
		logic [1:0] rate;
		logic       speed;
	} apc_ctrl_s;
	localparam apc_ctrl_s CTRL_RESET = '{gain: 3'h0, rate: 2'h0, speed: 1'b0};
	typedef enum logic {APC_RUN, APC_SLEEP} apc_pwr_e;
endpackage
`default_nettype wire

// ### apc_top.sv
// Module: command decode, power state and rate generation of the converter
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Sync opcode restarts conversion timing and ready
// - Sleep opcode enters low power until wake or reset opcode
// - Reset opcode returns the control register to defaults
// - Reset opcode also ends automatic readout
// - Data rate is oscillator over 128*2^s*1280*2^dr, with dr limited to 2
// - Modulator rate is oscillator over 128*2^speed
// - Sampling rate scales x2/x4/x8 with high gain
// - One new result every output data period
// - Result sign follows positive minus negative input
// - Wake opcode leaves sleep and resumes
// - Command bytes arrive most significant bit first
// - Automatic readout starts on every new result
module apc_top (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial command input
	input  wire logic        cmd_bit,
	input  wire logic        cmd_bit_valid,
	// Converter inputs
	input  wire logic [23:0] ain_pos,
	input  wire logic [23:0] ain_neg,
	// Converter outputs
	output logic             modulator_rate,
	output logic             input_sampling_rate,
	output logic             result_ready_n,
	output logic             readout_start,
	output logic             auto_readout_mode,
	output logic             sleep_state
);
	apc_pkg::apc_ctrl_s ctrl_reg, ctrl_next;
	apc_pkg::apc_pwr_e  pwr_reg, pwr_next;
	logic [6:0]  shift_reg, shift_next;
	logic [2:0]  bit_cnt_reg, bit_cnt_next;
	logic        auto_reg, auto_next;
	logic [8:0]  mod_cnt_reg, mod_cnt_next;
	logic [8:0]  samp_cnt_reg, samp_cnt_next;
	logic [12:0] conv_cnt_reg, conv_cnt_next;
	logic        mod_tick_reg, mod_tick_next;
	logic        samp_tick_reg, samp_tick_next;
	logic        ready_n_reg, ready_n_next;
	logic        start_reg, start_next;
	logic [23:0] result_reg, result_next;
	logic [15:0] count_reg, count_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic        cmd_done;
	logic [7:0]  cmd_byte;
	logic        restart;
	logic        complete;
	logic        apb_wr;
	logic        apb_rd_result;
	logic [8:0]  mod_div;
	logic [8:0]  samp_div;
	logic [1:0]  samp_shift;
	logic [12:0] conv_len;
	logic [1:0]  rate_eff;
	logic [24:0] diff;
	logic [23:0] diff_sat;

	// Command byte assembly
	always_comb begin
		cmd_done = cmd_bit_valid && (bit_cnt_reg == apc_pkg::CMD_LAST_BIT);
		cmd_byte = {shift_reg, cmd_bit};
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		if (cmd_bit_valid) begin
			shift_next = {shift_reg[5:0], cmd_bit};
			bit_cnt_next = bit_cnt_reg + 3'h1;
		end
	end

	// Command effects on mode, power and control
	always_comb begin
		ctrl_next = ctrl_reg;
		pwr_next = pwr_reg;
		auto_next = auto_reg;
		restart = 1'b0;
		apb_wr = psel && penable && pready_reg && pwrite;
		if (apb_wr && (paddr == apc_pkg::ADDR_CTRL)) begin
			ctrl_next = apc_pkg::apc_ctrl_s'(pwdata[apc_pkg::CTRL_W-1:0]);
		end
		if (cmd_done) begin
			unique case (cmd_byte)
				apc_pkg::CMD_SYNC: begin
					restart = 1'b1;
				end
				apc_pkg::CMD_SLEEP: begin
					pwr_next = apc_pkg::APC_SLEEP;
					restart = 1'b1;
				end
				apc_pkg::CMD_WAKE: begin
					pwr_next = apc_pkg::APC_RUN;
					restart = 1'b1;
				end
				apc_pkg::CMD_RESET: begin
					ctrl_next = apc_pkg::CTRL_RESET;
					auto_next = 1'b0;
					pwr_next = apc_pkg::APC_RUN;
					restart = 1'b1;
				end
				apc_pkg::CMD_AUTO: begin
					auto_next = 1'b1;
				end
				apc_pkg::CMD_STOP_AUTO: begin
					auto_next = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Rate dividers and conversion sequencing
	always_comb begin
		rate_eff = (ctrl_reg.rate > apc_pkg::RATE_MAX) ? apc_pkg::RATE_MAX : ctrl_reg.rate;
		mod_div = apc_pkg::MOD_BASE_DIV << ctrl_reg.speed;
		if (ctrl_reg.gain > apc_pkg::GAIN_32) begin
			samp_shift = apc_pkg::SHIFT_X8;
		end else if (ctrl_reg.gain == apc_pkg::GAIN_32) begin
			samp_shift = apc_pkg::SHIFT_X4;
		end else if (ctrl_reg.gain == apc_pkg::GAIN_16) begin
			samp_shift = apc_pkg::SHIFT_X2;
		end else begin
			samp_shift = 2'h0;
		end
		samp_div = mod_div >> samp_shift;
		conv_len = apc_pkg::CONV_MOD_TICKS << rate_eff;
		mod_tick_next = 1'b0;
		samp_tick_next = 1'b0;
		mod_cnt_next = mod_cnt_reg + 9'h001;
		samp_cnt_next = samp_cnt_reg + 9'h001;
		conv_cnt_next = conv_cnt_reg;
		complete = 1'b0;
		if (mod_cnt_reg >= mod_div - 9'h001) begin
			mod_cnt_next = 9'h000;
			mod_tick_next = 1'b1;
			conv_cnt_next = conv_cnt_reg + 13'h0001;
			if (conv_cnt_reg >= conv_len - 13'h0001) begin
				conv_cnt_next = 13'h0000;
				complete = 1'b1;
			end
		end
		if (samp_cnt_reg >= samp_div - 9'h001) begin
			samp_cnt_next = 9'h000;
			samp_tick_next = 1'b1;
		end
		if (restart || (pwr_reg == apc_pkg::APC_SLEEP)) begin
			mod_cnt_next = 9'h000;
			samp_cnt_next = 9'h000;
			conv_cnt_next = 13'h0000;
			mod_tick_next = 1'b0;
			samp_tick_next = 1'b0;
			complete = 1'b0;
		end
	end

	// Result capture, ready flag and readout start
	always_comb begin
		diff = {1'b0, ain_pos} - {1'b0, ain_neg};
		if (diff[24] != diff[23]) begin
			diff_sat = diff[24] ? apc_pkg::RES_NEG_FS : apc_pkg::RES_POS_FS;
		end else begin
			diff_sat = diff[23:0];
		end
		apb_rd_result = psel && penable && pready_reg && !pwrite && (paddr == apc_pkg::ADDR_RESULT);
		result_next = result_reg;
		count_next = count_reg;
		ready_n_next = ready_n_reg;
		start_next = 1'b0;
		if (apb_rd_result || restart) begin
			ready_n_next = 1'b1;
		end
		if (complete) begin
			result_next = diff_sat;
			count_next = count_reg + 16'h0001;
			ready_n_next = 1'b0;
			start_next = auto_reg;
		end
	end

	// APB slave: one wait-free access phase, unmapped addresses error
	always_comb begin
		pready_next = psel && !penable && !pready_reg;
		prdata_next = 32'h00000000;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			unique case (paddr)
				apc_pkg::ADDR_CTRL: begin
					prdata_next = {26'h0000000, ctrl_reg};
				end
				apc_pkg::ADDR_STATUS: begin
					prdata_next[apc_pkg::ST_SLEEP] = (pwr_reg == apc_pkg::APC_SLEEP);
					prdata_next[apc_pkg::ST_AUTO] = auto_reg;
					prdata_next[apc_pkg::ST_READY] = !ready_n_reg;
				end
				apc_pkg::ADDR_RESULT: begin
					prdata_next = {8'h00, result_reg};
				end
				apc_pkg::ADDR_COUNT: begin
					prdata_next = {16'h0000, count_reg};
				end
				default: begin
					pslverr_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= apc_pkg::CTRL_RESET;
			pwr_reg <= apc_pkg::APC_RUN;
			shift_reg <= 7'h00;
			bit_cnt_reg <= 3'h0;
			auto_reg <= 1'b0;
			mod_cnt_reg <= 9'h000;
			samp_cnt_reg <= 9'h000;
			conv_cnt_reg <= 13'h0000;
			mod_tick_reg <= 1'b0;
			samp_tick_reg <= 1'b0;
			ready_n_reg <= 1'b1;
			start_reg <= 1'b0;
			result_reg <= 24'h000000;
			count_reg <= 16'h0000;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			pwr_reg <= pwr_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			auto_reg <= auto_next;
			mod_cnt_reg <= mod_cnt_next;
			samp_cnt_reg <= samp_cnt_next;
			conv_cnt_reg <= conv_cnt_next;
			mod_tick_reg <= mod_tick_next;
			samp_tick_reg <= samp_tick_next;
			ready_n_reg <= ready_n_next;
			start_reg <= start_next;
			result_reg <= result_next;
			count_reg <= count_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign modulator_rate = mod_tick_reg;
	assign input_sampling_rate = samp_tick_reg;
	assign result_ready_n = ready_n_reg;
	assign readout_start = start_reg;
	assign auto_readout_mode = auto_reg;
	assign sleep_state = (pwr_reg == apc_pkg::APC_SLEEP);

	// Checking helpers: cycles since the last tick, and a control change that spoils a period
	logic [8:0] gap_mod, gap_samp;
	logic       mod_dirty, samp_dirty;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_mod <= 9'h000;
			gap_samp <= 9'h000;
			mod_dirty <= 1'b0;
			samp_dirty <= 1'b0;
		end else begin
			gap_mod <= (restart || sleep_state) ? 9'h000 : mod_tick_reg ? 9'h001 : gap_mod + 9'h001;
			gap_samp <= (restart || sleep_state) ? 9'h000 : samp_tick_reg ? 9'h001 : gap_samp + 9'h001;
			mod_dirty <= (ctrl_next != ctrl_reg) || (mod_dirty && !mod_tick_reg);
			samp_dirty <= (ctrl_next != ctrl_reg) || (samp_dirty && !samp_tick_reg);
		end
	end

	chk_sync_restart: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done && (cmd_byte == apc_pkg::CMD_SYNC) |=> (conv_cnt_reg == 13'h0000) && ready_n_reg [*8])
		else $error("sync did not restart conversion");
	chk_sleep_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done && (cmd_byte == apc_pkg::CMD_SLEEP) |=> sleep_state ##1 !mod_tick_reg [*8])
		else $error("modulator ran in sleep");
	chk_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_state && cmd_done && (cmd_byte == apc_pkg::CMD_WAKE) |=> !sleep_state ##[1:300] mod_tick_reg)
		else $error("wake did not resume modulator");
	chk_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done && (cmd_byte == apc_pkg::CMD_RESET) |=> (ctrl_reg == apc_pkg::CTRL_RESET) && !auto_readout_mode)
		else $error("reset command left state");
	chk_mod_period: assert property (@(posedge pclk) disable iff (!presetn)
		mod_tick_reg && !mod_dirty |-> gap_mod == mod_div)
		else $error("modulator period wrong");
	chk_samp_period: assert property (@(posedge pclk) disable iff (!presetn)
		samp_tick_reg && !samp_dirty |-> gap_samp == samp_div)
		else $error("sampling period wrong");
	chk_result_ready: assert property (@(posedge pclk) disable iff (!presetn)
		complete |=> !result_ready_n && (count_reg == $past(count_reg) + 16'h0001) && mod_tick_reg)
		else $error("result not delivered");
	chk_result_sign: assert property (@(posedge pclk) disable iff (!presetn)
		complete |=> (result_reg[23] == ($past(ain_pos) < $past(ain_neg))) || (result_reg == 24'h000000))
		else $error("result sign wrong");
	chk_auto_start: assert property (@(posedge pclk) disable iff (!presetn)
		complete && auto_reg |=> readout_start ##1 !readout_start)
		else $error("automatic readout missed");
	chk_byte_order: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_bit_valid |=> (shift_reg[0] == $past(cmd_bit)) && (bit_cnt_reg == $past(bit_cnt_reg) + 3'h1) && ($past(cmd_done) ? bit_cnt_reg == 3'h0 : 1'b1))
		else $error("command bit order wrong");
endmodule
`default_nettype wire

// ### apc_host_model.sv
// Host model that sends command bytes over the serial command port
`timescale 1ns/10ps
`default_nettype none
module apc_host_model (
	// Clock
	input  wire logic pclk,
	// Serial command output
	output logic      cmd_bit,
	output logic      cmd_bit_valid
);
	initial begin
		cmd_bit       = 1'b0;
		cmd_bit_valid = 1'b0;
	end
	// Sends one byte; keep holds the strobe up for a byte that follows at once
	task automatic send(input logic [7:0] b, input bit keep);
		for (int i = 7; i >= 0; i--) begin
			cmd_bit       <= b[i];
			cmd_bit_valid <= 1'b1;
			@(posedge pclk);
		end
		if (!keep) begin
			cmd_bit_valid <= 1'b0;
			cmd_bit       <= ~b[0];
		end
	endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Testbench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        cmd_bit, cmd_bit_valid, modulator_rate, input_sampling_rate;
	logic        result_ready_n, readout_start, auto_readout_mode, sleep_state;
	logic [23:0] ain_pos, ain_neg;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          seed, p, n, k, sp, rt, d;

	apc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmd_bit(cmd_bit), .cmd_bit_valid(cmd_bit_valid), .ain_pos(ain_pos), .ain_neg(ain_neg),
		.modulator_rate(modulator_rate), .input_sampling_rate(input_sampling_rate),
		.result_ready_n(result_ready_n), .readout_start(readout_start),
		.auto_readout_mode(auto_readout_mode), .sleep_state(sleep_state));
	apc_host_model host (.pclk(pclk), .cmd_bit(cmd_bit), .cmd_bit_valid(cmd_bit_valid));

	always #12.5 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("Errors: %0d Comparisons: %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Cycles between two pulses of the selected rate output
	task automatic gap(input bit s, output int g);
		for (int j = 0; j < 3; j++) begin
			g = 0;
			do begin
				@(posedge pclk);
				g++;
			end while ((s ? input_sampling_rate : modulator_rate) !== 1'b1 && g < 2000);
		end
	endtask

	initial begin
		#(25 * 200000);
		num_errors++;
		test_done;
	end

	initial begin
		seed    = 91902;
		pclk    = 1'b0;
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		ain_pos = 24'h000000;
		ain_neg = 24'h000000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		for (int g = 0; g < 8; g++) begin
			sp = $random(seed) & 1;
			rt = $unsigned($random(seed)) % 3;
			apb(1'b1, 8'h00, {26'h0, g[2:0], rt[1:0], sp[0]});
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, {26'h0, g[2:0], rt[1:0], sp[0]});
			k = (g < 4) ? 0 : (g == 4) ? 1 : (g == 5) ? 2 : 3;
			gap(1'b0, p);
			chk(p, 128 << sp);
			gap(1'b1, p);
			chk(p, (128 << sp) >> k);
		end
		host.send(8'hbf, 1'b0);
		@(posedge pclk);
		chk(sleep_state, 1'b0);
		host.send(8'hfd, 1'b0);
		@(posedge pclk);
		chk(sleep_state, 1'b1);
		n = 0;
		repeat (600) begin
			@(posedge pclk);
			n += modulator_rate;
		end
		chk(n, 0);
		host.send(8'hfb, 1'b0);
		@(posedge pclk);
		chk(sleep_state, 1'b0);
		gap(1'b0, p);
		chk(p, 128 << sp);
		sp = 0;
		rt = 0;
		apb(1'b1, 8'h00, 32'h0);
		d = $random(seed);
		ain_pos <= d[23:0];
		d = $random(seed);
		ain_neg <= d[23:0];
		host.send(8'h03, 1'b0);
		@(posedge pclk);
		chk(auto_readout_mode, 1'b1);
		host.send(8'hfc, 1'b0);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (result_ready_n !== 1'b0 && n < 170000);
		chk(readout_start, 1'b1);
		p = (128 << sp) * (1280 << rt);
		chk(n >= p - 2 && n <= p + 2, 1'b1);
		d = int'(ain_pos) - int'(ain_neg);
		d = (d > 8388607) ? 8388607 : (d < -8388608) ? -8388608 : d;
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[23:0], d[23:0]);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[15:0], 16'h0001);
		host.send(8'h0f, 1'b0);
		@(posedge pclk);
		chk(auto_readout_mode, 1'b0);
		host.send(8'h03, 1'b0);
		apb(1'b1, 8'h00, 32'h2d);
		chk(auto_readout_mode, 1'b1);
		host.send(8'hfe, 1'b1);
		host.send(8'hfd, 1'b0);
		@(posedge pclk);
		chk(auto_readout_mode, 1'b0);
		chk(sleep_state, 1'b1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		test_done;
	end
endmodule
`default_nettype wire
